// [mex_pkg.sv]
// constants for the instruction execution block: register map, instruction
// word layout, opcodes, flag positions, reset values and the sequencer states.
// assumes a 32-bit APB master on the same clock as the block.
package mex_pkg;

    localparam logic [7:0] OFS_INSTR     = 8'h00;
    localparam logic [7:0] OFS_ACC       = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam logic [7:0] OFS_PC        = 8'h0C;
    localparam logic [7:0] OFS_STACK     = 8'h10;
    localparam logic [7:0] OFS_MEM_ADDR  = 8'h14;
    localparam logic [7:0] OFS_MEM_DATA  = 8'h18;

    localparam int unsigned OP_LSB       = 0;
    localparam int unsigned OP_W         = 3;
    localparam int unsigned OPND_LSB     = 8;
    localparam int unsigned TGT_LSB      = 16;

    localparam logic [2:0] OPC_ADD_TO_MEM   = 3'h1;
    localparam logic [2:0] OPC_MEM_MASK_ACC = 3'h2;
    localparam logic [2:0] OPC_IMM_MASK_ACC = 3'h3;
    localparam logic [2:0] OPC_ACC_MASK_MEM = 3'h4;
    localparam logic [2:0] OPC_SUBR_JUMP    = 3'h5;
    localparam logic [2:0] OPC_MEMORY_ZERO  = 3'h6;

    localparam int unsigned FLG_MSB_SPILL   = 0;
    localparam int unsigned FLG_HALF_CARRY  = 1;
    localparam int unsigned FLG_RESULT_NULL = 2;
    localparam int unsigned FLG_SIGNED_RNG  = 3;
    localparam int unsigned STS_BUSY        = 8;

    localparam logic [7:0] ACC_RST   = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    typedef enum logic [3:0] {
        MEX_IDLE = 4'b0001,
        MEX_EXEC = 4'b0010,
        MEX_PUSH = 4'b0100,
        MEX_JUMP = 4'b1000
    } mex_state_t;

endpackage

// [mex_core.sv]
// execution unit for a subset of an 8-bit core's instructions, driven over APB.
// assumes an APB master on SYS_CLK; an instruction is launched by writing INSTR.
//
// Notes on behaviour
// - add acc into memory byte, four flags
// - and memory into acc, zero flag only
// - and immediate into acc, zero flag only
// - and acc into memory byte
// - call pushes pc plus one, loads target
// - call takes two cycles
// - memory clear writes zero, flags untouched
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mex_core
    import mex_pkg::*;
#(
    parameter int unsigned PC_W    = 12,
    parameter int unsigned STACK_D = 8,
    parameter int unsigned MEM_D   = 256
) (
    input  wire logic        SYS_CLK,  // core clock
    input  wire logic        ARST_N,   // async reset, active low
    input  wire logic        PSEL,     // apb select
    input  wire logic        PENABLE,  // apb access phase
    input  wire logic        PWRITE,   // apb direction
    input  wire logic [7:0]  PADDR,    // apb byte address
    input  wire logic [31:0] PWDATA,   // apb write data
    output logic      [31:0] PRDATA,   // apb read data
    output logic             PREADY,   // apb ready
    output logic             PSLVERR   // apb error on unmapped address
);

    localparam int unsigned AW = $clog2(MEM_D);
    localparam int unsigned SW = $clog2(STACK_D);

    // refuse sizes that the readback layout and the power-of-two indexing cannot serve
    if (PC_W < 2 || PC_W > 16 || MEM_D < 2 || MEM_D > 256 || (1 << AW) != MEM_D ||
        STACK_D < 2 || (1 << SW) != STACK_D) begin
        $error("mex_core: unsupported parameter values");
    end

    mex_state_t          state_q, state_d;
    logic [7:0]          acc_q;
    logic [3:0]          flags_q;
    logic [PC_W-1:0]     pc_q;
    logic [SW-1:0]       sp_q;
    logic [OP_W-1:0]     op_q;
    logic [7:0]          opnd_q;
    logic [PC_W-1:0]     tgt_q;
    logic [AW-1:0]       maddr_q;
    logic                pready_q, pslverr_q;
    logic [31:0]         prdata_q;
    logic [7:0]          mem   [MEM_D];
    logic [PC_W-1:0]     stack [STACK_D];

    // apb decode: answer one cycle after select, held off while executing
    wire idle      = (state_q == MEX_IDLE);
    wire answer    = PSEL & ~pready_q & idle;
    wire xfer      = PSEL & PENABLE & pready_q;
    wire wr        = xfer & PWRITE;
    wire hit_instr = (PADDR == OFS_INSTR);
    wire hit_acc   = (PADDR == OFS_ACC);
    wire hit_sts   = (PADDR == OFS_STATUS);
    wire hit_pc    = (PADDR == OFS_PC);
    wire hit_stk   = (PADDR == OFS_STACK);
    wire hit_madr  = (PADDR == OFS_MEM_ADDR);
    wire hit_mdat  = (PADDR == OFS_MEM_DATA);
    wire mapped    = hit_instr | hit_acc | hit_sts | hit_pc | hit_stk | hit_madr | hit_mdat;
    wire launch    = wr & hit_instr;

    // datapath
    wire [AW-1:0]   midx     = opnd_q[AW-1:0];
    wire [7:0]      mem_rd   = mem[midx];
    wire [8:0]      sum      = {1'b0, acc_q} + {1'b0, mem_rd};
    wire [4:0]      half     = {1'b0, acc_q[3:0]} + {1'b0, mem_rd[3:0]};
    wire            ovf      = (acc_q[7] == mem_rd[7]) && (sum[7] != acc_q[7]);
    wire [7:0]      and_mem  = acc_q & mem_rd;
    wire [7:0]      and_imm  = acc_q & opnd_q;
    wire [PC_W-1:0] pc_inc   = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
    wire [SW-1:0]   sp_top   = sp_q - {{(SW-1){1'b0}}, 1'b1};
    wire            exec     = (state_q == MEX_EXEC);
    wire            ex_add   = exec && (op_q == OPC_ADD_TO_MEM);
    wire            ex_andm  = exec && (op_q == OPC_MEM_MASK_ACC);
    wire            ex_andi  = exec && (op_q == OPC_IMM_MASK_ACC);
    wire            ex_tomem = exec && (op_q == OPC_ACC_MASK_MEM);
    wire            ex_clr   = exec && (op_q == OPC_MEMORY_ZERO);

    function automatic logic is_zero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction

    always_comb begin
        unique case (state_q)
            MEX_IDLE: state_d = !launch ? MEX_IDLE :
                                (PWDATA[OP_LSB +: OP_W] == OPC_SUBR_JUMP) ? MEX_PUSH : MEX_EXEC;
            MEX_EXEC: state_d = MEX_IDLE;
            MEX_PUSH: state_d = MEX_JUMP;
            MEX_JUMP: state_d = MEX_IDLE;
            default:  state_d = MEX_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= MEX_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            op_q    <= '0;
            opnd_q  <= 8'h00;
            tgt_q   <= '0;
            maddr_q <= '0;
        end else begin
            if (launch) begin
                op_q   <= PWDATA[OP_LSB +: OP_W];
                opnd_q <= PWDATA[OPND_LSB +: 8];
                tgt_q  <= PWDATA[TGT_LSB +: PC_W];
            end
            if (wr && hit_madr) begin
                maddr_q <= PWDATA[AW-1:0];
            end
        end
    end

    // accumulator and flags
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            acc_q   <= ACC_RST;
            flags_q <= FLAGS_RST;
        end else begin
            if (wr && hit_acc) begin
                acc_q <= PWDATA[7:0];
            end else if (ex_andm) begin
                acc_q <= and_mem;
            end else if (ex_andi) begin
                acc_q <= and_imm;
            end
            if (wr && hit_sts) begin
                flags_q <= PWDATA[3:0];
            end else if (ex_add) begin
                flags_q[FLG_MSB_SPILL]   <= sum[8];
                flags_q[FLG_HALF_CARRY]  <= half[4];
                flags_q[FLG_RESULT_NULL] <= is_zero(sum[7:0]);
                flags_q[FLG_SIGNED_RNG]  <= ovf;
            end else if (ex_andm) begin
                flags_q[FLG_RESULT_NULL] <= is_zero(and_mem);
            end else if (ex_andi) begin
                flags_q[FLG_RESULT_NULL] <= is_zero(and_imm);
            end else if (ex_tomem) begin
                flags_q[FLG_RESULT_NULL] <= is_zero(and_mem);
            end
        end
    end

    // program counter and return stack
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc_q <= '0;
            sp_q <= '0;
        end else begin
            if (wr && hit_pc) begin
                pc_q <= PWDATA[PC_W-1:0];
            end else if (exec) begin
                pc_q <= pc_inc;
            end else if (state_q == MEX_JUMP) begin
                pc_q <= tgt_q;
            end
            if (state_q == MEX_PUSH) begin
                sp_q <= sp_q + {{(SW-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (state_q == MEX_PUSH) begin
            stack[sp_q] <= pc_inc;
        end
    end

    // data memory: execution and the software window never collide
    always_ff @(posedge SYS_CLK) begin
        if (wr && hit_mdat) begin
            mem[maddr_q] <= PWDATA[7:0];
        end else if (ex_add) begin
            mem[midx] <= sum[7:0];
        end else if (ex_tomem) begin
            mem[midx] <= and_mem;
        end else if (ex_clr) begin
            mem[midx] <= 8'h00;
        end
    end

    // apb answer
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_instr) rd_mux = {{(16-PC_W){1'b0}}, tgt_q, opnd_q, 5'h00, op_q};
        if (hit_acc)   rd_mux = {24'h00_0000, acc_q};
        if (hit_sts)   rd_mux = {23'h00_0000, ~idle, 4'h0, flags_q};
        if (hit_pc)    rd_mux = {{(32-PC_W){1'b0}}, pc_q};
        if (hit_stk)   rd_mux = {{(32-PC_W){1'b0}}, stack[sp_top]};
        if (hit_madr)  rd_mux = {{(32-AW){1'b0}}, maddr_q};
        if (hit_mdat)  rd_mux = {24'h00_0000, mem[maddr_q]};
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= answer;
            pslverr_q <= answer & ~mapped;
            if (answer) begin
                prdata_q <= PWRITE ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    assign PREADY  = pready_q;
    assign PSLVERR = pslverr_q;
    assign PRDATA  = prdata_q;

    // checks
    AST_ADD_MEM: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ex_add |=> mem[$past(midx)] == $past(sum[7:0]) &&
                   flags_q[FLG_HALF_CARRY] == $past(half[4]) && flags_q[FLG_SIGNED_RNG] == $past(ovf))
        else $error("add to memory result or flags wrong");
    AST_MEM_MASK: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ex_andm |=> acc_q == $past(acc_q & mem_rd) && flags_q[1:0] == $past(flags_q[1:0]) &&
                    flags_q[FLG_SIGNED_RNG] == $past(flags_q[FLG_SIGNED_RNG]))
        else $error("memory mask into acc wrong");
    AST_IMM_MASK: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ex_andi |=> acc_q == $past(acc_q & opnd_q) && flags_q[1:0] == $past(flags_q[1:0]))
        else $error("immediate mask into acc wrong");
    AST_TO_MEM: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ex_tomem |=> mem[$past(midx)] == $past(and_mem) && $stable(acc_q))
        else $error("acc mask into memory wrong");
    AST_CALL_PUSH: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        state_q == MEX_PUSH |=> stack[$past(sp_q)] == $past(pc_inc) ##1 pc_q == $past(tgt_q, 2) &&
                                flags_q == $past(flags_q, 2))
        else $error("call push or jump wrong");
    AST_CALL_TWO: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        (idle && launch && PWDATA[OP_LSB +: OP_W] == OPC_SUBR_JUMP) |=>
            state_q == MEX_PUSH ##1 state_q == MEX_JUMP ##1 idle)
        else $error("call did not take two cycles");
    AST_CLEAR: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ex_clr |=> mem[$past(midx)] == 8'h00 && $stable(flags_q))
        else $error("memory clear wrong");
    AST_NULL_FLAG: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ex_add |=> flags_q[FLG_RESULT_NULL] == (mem[$past(midx)] == 8'h00) &&
                   flags_q[FLG_MSB_SPILL] == $past(sum[8]))
        else $error("zero or carry flag wrong");
    AST_HOLD_OFF: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        !idle |-> !pready_q)
        else $error("answered while busy");

    COV_ADD_CARRY: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) ex_add && sum[8]);
    COV_CALL:      cover property (@(posedge SYS_CLK) disable iff (!ARST_N)
        state_q == MEX_PUSH ##1 state_q == MEX_JUMP);
    COV_CLEAR:     cover property (@(posedge SYS_CLK) disable iff (!ARST_N) ex_clr);
    COV_ERR:       cover property (@(posedge SYS_CLK) disable iff (!ARST_N) pslverr_q);

endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the instruction execution block: apb tasks, then one
// sequence of instruction launches with expected memory, acc, pc, stack and flags.
// assumes mex_core with its default parameters and mex_pkg on the compile list.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mex_pkg::*;

    logic        SYS_CLK;
    logic        ARST_N;
    logic        PSEL;
    logic        PENABLE;
    logic        PWRITE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    int          mismatches;
    int          n_checks;
    int          n_wait;
    int          w_single;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  av [4] = '{8'h0F, 8'h7F, 8'hFF, 8'h88};
    logic [7:0]  mv [4] = '{8'h01, 8'h01, 8'h01, 8'h88};
    logic [8:0]  s;
    logic [31:0] fl;

    mex_core i_dut (
        .SYS_CLK (SYS_CLK),
        .ARST_N  (ARST_N),
        .PSEL    (PSEL),
        .PENABLE (PENABLE),
        .PWRITE  (PWRITE),
        .PADDR   (PADDR),
        .PWDATA  (PWDATA),
        .PRDATA  (PRDATA),
        .PREADY  (PREADY),
        .PSLVERR (PSLVERR)
    );

    always #5 SYS_CLK = ~SYS_CLK;

    task automatic report_and_stop;
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; pready is sampled as it stood before each edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge SYS_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        n_wait = 0;
        do begin
            @(posedge SYS_CLK);
            n_wait++;
        end while (PREADY !== 1'b1 && n_wait < 50);
        if (n_wait >= 50) begin
            mismatches++;
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic setmem(input logic [7:0] a, input logic [7:0] d);
        wr(OFS_MEM_ADDR, {24'h0, a});
        wr(OFS_MEM_DATA, {24'h0, d});
    endtask

    task automatic op(input logic [2:0] opc, input logic [7:0] opnd, input logic [11:0] tgt);
        wr(OFS_INSTR, {4'h0, tgt, opnd, 5'h0, opc});
    endtask

    initial begin
        #100000;
        mismatches++;
        report_and_stop;
    end

    initial begin
        SYS_CLK = 1'b0;
        ARST_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        mismatches = 0;
        n_checks = 0;
        repeat (5) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        rchk(OFS_ACC, {24'h0, ACC_RST});
        rchk(OFS_STATUS, {28'h0, FLAGS_RST});
        rchk(OFS_PC, 32'h0);
        // add into memory: carry, half carry, zero and signed range cases
        for (int i = 0; i < 4; i++) begin
            setmem(8'h10, mv[i]);
            wr(OFS_ACC, {24'h0, av[i]});
            op(OPC_ADD_TO_MEM, 8'h10, 12'h0);
            s = {1'b0, av[i]} + {1'b0, mv[i]};
            fl = 32'h0;
            fl[FLG_MSB_SPILL] = s[8];
            fl[FLG_HALF_CARRY] = ({1'b0, av[i][3:0]} + {1'b0, mv[i][3:0]}) > 5'h0F;
            fl[FLG_RESULT_NULL] = (s[7:0] == 8'h00);
            fl[FLG_SIGNED_RNG] = (av[i][7] == mv[i][7]) && (s[7] != av[i][7]);
            rchk(OFS_MEM_DATA, {24'h0, s[7:0]});
            rchk(OFS_STATUS, fl);
        end
        rchk(OFS_PC, 32'h4);
        wr(OFS_STATUS, 32'h0B);
        setmem(8'h20, 8'h0F);
        wr(OFS_ACC, 32'hF0);
        op(OPC_MEM_MASK_ACC, 8'h20, 12'h0);
        rchk(OFS_ACC, 32'h0);
        rchk(OFS_STATUS, 32'h0F);
        rchk(OFS_MEM_DATA, 32'h0F);
        wr(OFS_ACC, 32'h3C);
        op(OPC_MEM_MASK_ACC, 8'h20, 12'h0);
        rchk(OFS_ACC, 32'h0C);
        rchk(OFS_STATUS, 32'h0B);
        wr(OFS_ACC, 32'h5A);
        op(OPC_IMM_MASK_ACC, 8'hA5, 12'h0);
        rchk(OFS_ACC, 32'h0);
        rchk(OFS_STATUS, 32'h0F);
        wr(OFS_ACC, 32'hFF);
        op(OPC_IMM_MASK_ACC, 8'h81, 12'h0);
        rchk(OFS_ACC, 32'h81);
        rchk(OFS_STATUS, 32'h0B);
        setmem(8'h30, 8'h3E);
        wr(OFS_ACC, 32'hC3);
        op(OPC_ACC_MASK_MEM, 8'h30, 12'h0);
        rchk(OFS_MEM_DATA, 32'h02);
        rchk(OFS_ACC, 32'hC3);
        wr(OFS_STATUS, 32'h0A);
        setmem(8'h40, 8'hFF);
        op(OPC_MEMORY_ZERO, 8'h40, 12'h0);
        rchk(OFS_MEM_DATA, 32'h0);
        w_single = n_wait;
        rchk(OFS_STATUS, 32'h0A);
        rchk(OFS_MEM_ADDR, 32'h40);
        // call: stack gets pc plus one, flags kept, one cycle longer than a single op
        wr(OFS_STATUS, 32'h05);
        wr(OFS_PC, 32'h123);
        op(OPC_SUBR_JUMP, 8'h00, 12'hABC);
        rchk(OFS_PC, 32'hABC);
        chk(32'(n_wait), 32'(w_single + 1));
        rchk(OFS_STACK, 32'h124);
        rchk(OFS_STATUS, 32'h05);
        rchk(OFS_INSTR, {4'h0, 12'hABC, 8'h00, 5'h0, OPC_SUBR_JUMP});
        // unmapped address answers with an error and reads zero
        wr(8'h1C, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        report_and_stop;
    end
endmodule
`default_nettype wire
